// ### hw/ast_defines.svh
/*
 * Register offsets, field positions, reset values and sample counts of
 * the serial transceiver. Assumes a byte-addressed plain register port.
 */
`ifndef AST_DEFINES_SVH
`define AST_DEFINES_SVH
// Register byte offsets.
`define AST_OFS_DATA 12'h000
`define AST_OFS_RSTAT 12'h004
`define AST_OFS_FLAG 12'h018
`define AST_OFS_IDIV 12'h024
`define AST_OFS_FDIV 12'h028
`define AST_OFS_LCTL 12'h02C
`define AST_OFS_PCTL 12'h030
`define AST_OFS_LVL 12'h034
// Line control fields.
`define AST_LC_BRK 0
`define AST_LC_PEN 1
`define AST_LC_EPS 2
`define AST_LC_STP2 3
`define AST_LC_FEN 4
`define AST_LC_WLEN 5
`define AST_LC_SPS 7
// Port control fields and reset value.
`define AST_PC_EN 0
`define AST_PC_TXE 8
`define AST_PC_RXE 9
`define AST_PC_RESET 10'h300
// Trigger level select reset: half full for both directions.
`define AST_LVL_RESET 6'h12
// Flag register fields.
`define AST_FL_BUSY 3
`define AST_FL_RXFE 4
`define AST_FL_TXFF 5
`define AST_FL_RXFF 6
`define AST_FL_TXFE 7
`define AST_FL_TXEV 8
`define AST_FL_RXEV 9
// Receive status fields; the first four match the data entry flags.
`define AST_RS_FE 0
`define AST_RS_PE 1
`define AST_RS_BE 2
`define AST_RS_OE 3
`define AST_RS_SE 4
// Oversample counts: last tick of a bit and the start-bit midpoint.
`define AST_OS_LAST 4'hF
`define AST_OS_MID 4'h7
`endif

// ### hw/ast_pkg.sv
/*
 * Types shared by the serial transceiver.
 * Assumes nothing of its surroundings.
 */
package ast_pkg;
   // Frame position, used by both the transmitter and the receiver.
   typedef enum logic [4:0] {
      AST_IDLE   = 5'b00001,
      AST_START  = 5'b00010,
      AST_DATA   = 5'b00100,
      AST_PARITY = 5'b01000,
      AST_STOP   = 5'b10000
   } ast_state_t;
endpackage

// ### hw/ast_serial_core.sv
/*
 * Asynchronous serial transmitter and receiver with FIFOs, a fractional
 * baud generator and a plain register port. Assumes a synchronous receive
 * line and a register master that never issues read and write together.
 */
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ps
`include "ast_defines.svh"

// Overview of operation
// - Divisor is 16-bit integer plus 6-bit fraction.
// - Divisor equals clock over sixteen times baud.
// - Oversample tick at sixteen times baud rate.
// - Divisor and line settings latch on line write.
// - Frame: start, data LSB first, parity, stop.
// - Five to eight data bits selectable.
// - Even, odd, stick or no parity.
// - One or two stop bits appended.
// - Break generated on transmit, detected on receive.
// - Enabled port sends until transmit FIFO empty.
// - Busy while FIFO non-empty or frame shifting.
// - Start bit accepted only if low at tick eight.
// - Data sampled every sixteen ticks after start.
// - Stop bit high, otherwise framing error.
// - Sixteen-entry FIFOs; receive entries carry four flags.
// - False start bits visible in receive status.
// - Separate transmit and receive enables, set at reset.
// - Disabling finishes the current character first.
// - FIFOs switchable between full depth and single entry.
// - Trigger levels eighth, quarter, half, three quarters, seven eighths.
// - FIFOs single entry after reset until enabled.
// - Data read gives twelve bits; write queues eight.
// - Level events at trigger; both default half.
module ast_serial_core #(
   parameter int DEPTH = 16,            // FIFO capacity in characters.
   parameter int AW    = 4              // FIFO index width.
) (
   input  wire logic        clk_sys,    // System clock.
   input  wire logic        rst_n,      // Asynchronous reset, active low.
   input  wire logic [11:0] addr,       // Register byte address.
   input  wire logic [31:0] wr_data,    // Register write data.
   input  wire logic        wr,         // Write strobe.
   input  wire logic        rd,         // Read strobe.
   output logic      [31:0] rd_data,    // Read data, one cycle after rd.
   input  wire logic        serial_rx,  // Receive line, idle high.
   output logic             serial_tx,  // Transmit line, idle high.
   output logic             tx_event,   // Transmit level reached.
   output logic             rx_event    // Receive level reached.
);
   // Software-visible registers.
   logic [15:0] idiv;                   // Integer divisor as written.
   logic [5:0]  fdiv;                   // Fraction divisor as written.
   logic [29:0] cfg;                    // Latched line, integer, fraction.
   logic [9:0]  pctl;                   // Port control.
   logic [5:0]  lvl;                    // Trigger level selects.
   logic [4:0]  rsr;                    // Sticky receive status.

   // Line settings taken from the latched word.
   wire  [7:0]  lc    = cfg[29:22];
   wire  [21:0] div   = cfg[21:0];
   wire         brk   = lc[`AST_LC_BRK];
   wire         pen   = lc[`AST_LC_PEN];
   wire         eps   = lc[`AST_LC_EPS];
   wire         stp2  = lc[`AST_LC_STP2];
   wire         fifo_enable   = lc[`AST_LC_FEN];
   wire  [1:0]  wlen  = lc[`AST_LC_WLEN+:2];
   wire         sps   = lc[`AST_LC_SPS];
   wire         en    = pctl[`AST_PC_EN];
   wire  [2:0]  last  = 3'(wlen) + 3'd4;
   wire  [AW:0] cap   = fifo_enable ? (AW+1)'(DEPTH) : (AW+1)'(1);

   // Register decodes.
   wire wr_data_reg = wr && addr == `AST_OFS_DATA;
   wire rd_data_reg = rd && addr == `AST_OFS_DATA;
   wire wr_lctl     = wr && addr == `AST_OFS_LCTL;

   // Expected parity bit for a character of the current length.
   function automatic logic par_bit(input logic [7:0] d);
      logic [7:0] m;
      m = d & (8'hFF >> (2'd3 - wlen));
      if (sps)
         par_bit = ~eps;
      else
         par_bit = eps ? ^m : ~^m;
   endfunction

   // Fill level matching a trigger select.
   function automatic logic [AW:0] trig(input logic [2:0] s);
      case (s)
         3'd0:    trig = (AW+1)'(DEPTH / 8);
         3'd1:    trig = (AW+1)'(DEPTH / 4);
         3'd2:    trig = (AW+1)'(DEPTH / 2);
         3'd3:    trig = (AW+1)'(DEPTH * 3 / 4);
         default: trig = (AW+1)'(DEPTH * 7 / 8);
      endcase
   endfunction

   // Configuration writes; the shadow word moves only on a line write.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         idiv <= 16'h0000;
         fdiv <= 6'h00;
         cfg  <= 30'h0000_0000;
         pctl <= `AST_PC_RESET;
         lvl  <= `AST_LVL_RESET;
      end else if (wr) begin
         if (addr == `AST_OFS_IDIV)
            idiv <= wr_data[15:0];
         if (addr == `AST_OFS_FDIV)
            fdiv <= wr_data[5:0];
         if (wr_lctl)
            cfg <= {wr_data[7:0], idiv, fdiv};
         if (addr == `AST_OFS_PCTL)
            pctl <= wr_data[9:0];
         if (addr == `AST_OFS_LVL)
            lvl <= wr_data[5:0];
      end
   end

   // Fractional generator: steps of 64 against the divisor in 1/64 units.
   logic [22:0] acc;                    // Phase accumulator.
   logic        tick;                   // Oversample tick.
   wire  [22:0] acc_add = 23'(acc + 23'd64);
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         acc  <= 23'h00_0000;
         tick <= 1'b0;
      end else if (div == 22'h00_0000) begin
         acc  <= 23'h00_0000;
         tick <= 1'b0;
      end else if (acc_add >= {1'b0, div}) begin
         acc  <= 23'(acc_add - {1'b0, div});
         tick <= 1'b1;
      end else begin
         acc  <= acc_add;
         tick <= 1'b0;
      end
   end

   // Transmit FIFO storage and pointers.
   logic [7:0]    tx_mem [DEPTH];       // Queued characters.
   logic [AW-1:0] tx_wp;                // Write index.
   logic [AW-1:0] tx_rp;                // Read index.
   logic [AW:0]   tx_cnt;               // Fill level.
   wire           tx_full = tx_cnt >= cap;
   wire           tx_push = wr_data_reg && !tx_full;

   // Transmitter state.
   ast_pkg::ast_state_t tst;            // Frame position.
   logic [3:0]    tcnt;                 // Tick within bit.
   logic [2:0]    tbit;                 // Bit index.
   logic [7:0]    tsh;                  // Shift register.
   logic          tpar;                 // Parity of the character.
   wire tx_go  = tst == ast_pkg::AST_IDLE && tx_cnt != 0
                 && en && pctl[`AST_PC_TXE];
   wire tx_end = tick && tcnt == `AST_OS_LAST;

   // FIFO bookkeeping for the transmit side.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tx_wp  <= '0;
         tx_rp  <= '0;
         tx_cnt <= '0;
      end else begin
         if (tx_push) begin
            tx_mem[tx_wp] <= wr_data[7:0];
            tx_wp <= (tx_wp == AW'(DEPTH - 1)) ? '0 : AW'(tx_wp + 1'b1);
         end
         if (tx_go)
            tx_rp <= (tx_rp == AW'(DEPTH - 1)) ? '0 : AW'(tx_rp + 1'b1);
         tx_cnt <= (AW+1)'(tx_cnt + tx_push - tx_go);
      end
   end

   // Frame sequencer; an open frame ends even if the port is disabled.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tst  <= ast_pkg::AST_IDLE;
         tcnt <= 4'h0;
         tbit <= 3'd0;
         tsh  <= 8'h00;
         tpar <= 1'b0;
      end else if (tx_go) begin
         tst  <= ast_pkg::AST_START;
         tcnt <= 4'h0;
         tsh  <= tx_mem[tx_rp];
         tpar <= par_bit(tx_mem[tx_rp]);
      end else begin
         if (tick)
            tcnt <= 4'(tcnt + 1'b1);
         if (tx_end) begin
            case (tst)
               ast_pkg::AST_START: begin
                  tst  <= ast_pkg::AST_DATA;
                  tbit <= 3'd0;
               end
               ast_pkg::AST_DATA: begin
                  tsh  <= tsh >> 1;
                  tbit <= 3'(tbit + 1'b1);
                  if (tbit == last) begin
                     tst  <= pen ? ast_pkg::AST_PARITY : ast_pkg::AST_STOP;
                     tbit <= 3'd0;
                  end
               end
               ast_pkg::AST_PARITY:
                  tst <= ast_pkg::AST_STOP;
               ast_pkg::AST_STOP: begin
                  if (stp2 && tbit == 3'd0)
                     tbit <= 3'd1;
                  else
                     tst <= ast_pkg::AST_IDLE;
               end
               default:
                  tst <= ast_pkg::AST_IDLE;
            endcase
         end
      end
   end

   // Line level per frame position; break forces the line low.
   wire line_v = (tst == ast_pkg::AST_START)  ? 1'b0 :
                 (tst == ast_pkg::AST_DATA)   ? tsh[0] :
                 (tst == ast_pkg::AST_PARITY) ? tpar : 1'b1;
   wire busy_w = tx_cnt != 0 || tst != ast_pkg::AST_IDLE;

   // Receive FIFO storage and pointers.
   logic [11:0]   rx_mem [DEPTH];       // Character and four flags.
   logic [AW-1:0] rx_wp;                // Write index.
   logic [AW-1:0] rx_rp;                // Read index.
   logic [AW:0]   rx_cnt;               // Fill level.
   wire           rx_full = rx_cnt >= cap;
   wire           rx_pop  = rd_data_reg && rx_cnt != 0;

   // Receiver state.
   ast_pkg::ast_state_t rst;            // Frame position.
   logic [3:0]    rcnt;                 // Tick within bit.
   logic [2:0]    rbit;                 // Bit index.
   logic [7:0]    rsh;                  // Shift register, fills from top.
   logic          rpe;                  // Parity error seen.
   logic          rpb;                  // Received parity bit.
   logic          ovr_pend;             // Overrun to tag on next entry.
   wire  [7:0]    rdat   = rsh >> (2'd3 - wlen);
   wire           r_mid  = tick && rcnt == `AST_OS_LAST;
   wire           r_push = rst == ast_pkg::AST_STOP && r_mid;
   wire           r_fe   = !serial_rx;
   wire           r_be   = rdat == 8'h00 && !serial_rx
                           && !(pen && rpb);
   wire           r_ovr  = r_push && rx_full;
   wire           r_fls  = rst == ast_pkg::AST_START && tick
                           && rcnt == `AST_OS_MID && serial_rx;

   // Receive sequencer; an open frame ends even if the port is disabled.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rst  <= ast_pkg::AST_IDLE;
         rcnt <= 4'h0;
         rbit <= 3'd0;
         rsh  <= 8'h00;
         rpe  <= 1'b0;
         rpb  <= 1'b0;
      end else if (tick) begin
         rcnt <= 4'(rcnt + 1'b1);
         case (rst)
            ast_pkg::AST_IDLE: begin
               rcnt <= 4'h0;
               rpe  <= 1'b0;
               rpb  <= 1'b0;
               if (!serial_rx && en && pctl[`AST_PC_RXE])
                  rst <= ast_pkg::AST_START;
            end
            ast_pkg::AST_START: begin
               if (rcnt == `AST_OS_MID) begin
                  rcnt <= 4'h0;
                  rbit <= 3'd0;
                  rst  <= serial_rx ? ast_pkg::AST_IDLE
                                    : ast_pkg::AST_DATA;
               end
            end
            ast_pkg::AST_DATA: begin
               if (rcnt == `AST_OS_LAST) begin
                  rsh  <= {serial_rx, rsh[7:1]};
                  rbit <= 3'(rbit + 1'b1);
                  if (rbit == last)
                     rst <= pen ? ast_pkg::AST_PARITY : ast_pkg::AST_STOP;
               end
            end
            ast_pkg::AST_PARITY: begin
               if (rcnt == `AST_OS_LAST) begin
                  rpb <= serial_rx;
                  rpe <= serial_rx != par_bit(rdat);
                  rst <= ast_pkg::AST_STOP;
               end
            end
            ast_pkg::AST_STOP: begin
               if (rcnt == `AST_OS_LAST)
                  rst <= ast_pkg::AST_IDLE;
            end
            default:
               rst <= ast_pkg::AST_IDLE;
         endcase
      end
   end

   // Receive FIFO writes with per-character status, and reads.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rx_wp    <= '0;
         rx_rp    <= '0;
         rx_cnt   <= '0;
         ovr_pend <= 1'b0;
      end else begin
         if (r_push && !rx_full) begin
            rx_mem[rx_wp] <= {ovr_pend, r_be, rpe, r_fe, rdat};
            rx_wp <= (rx_wp == AW'(DEPTH - 1)) ? '0 : AW'(rx_wp + 1'b1);
            ovr_pend <= 1'b0;
         end else if (r_ovr) begin
            ovr_pend <= 1'b1;
         end
         if (rx_pop)
            rx_rp <= (rx_rp == AW'(DEPTH - 1)) ? '0 : AW'(rx_rp + 1'b1);
         rx_cnt <= (AW+1)'(rx_cnt + (r_push && !rx_full) - rx_pop);
      end
   end

   // Sticky status; a new event wins over a clear in the same cycle.
   wire [4:0] rs_set = {r_fls, r_ovr, 3'b000}
                     | (rx_pop ? {1'b0, rx_mem[rx_rp][11:8]} : 5'h00);
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n)
         rsr <= 5'h00;
      else if (wr && addr == `AST_OFS_RSTAT)
         rsr <= rs_set;
      else
         rsr <= rsr | rs_set;
   end

   // Flag word and read selection.
   wire [9:0] flags = {rx_cnt >= trig(lvl[5:3]),
                       tx_cnt <= trig(lvl[2:0]),
                       tx_cnt == 0, rx_full, tx_full, rx_cnt == 0,
                       busy_w, 3'b000};
   wire [31:0] rd_mux =
      (addr == `AST_OFS_DATA)  ? {20'h0_0000, rx_mem[rx_rp]} :
      (addr == `AST_OFS_RSTAT) ? {27'h000_0000, rsr} :
      (addr == `AST_OFS_FLAG)  ? {22'h00_0000, flags} :
      (addr == `AST_OFS_IDIV)  ? {16'h0000, idiv} :
      (addr == `AST_OFS_FDIV)  ? {26'h000_0000, fdiv} :
      (addr == `AST_OFS_LCTL)  ? {24'h00_0000, lc} :
      (addr == `AST_OFS_PCTL)  ? {22'h00_0000, pctl} :
      (addr == `AST_OFS_LVL)   ? {26'h000_0000, lvl} : 32'h0000_0000;

   // Registered outputs.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rd_data   <= 32'h0000_0000;
         serial_tx <= 1'b1;
         tx_event  <= 1'b0;
         rx_event  <= 1'b0;
      end else begin
         rd_data   <= rd ? rd_mux : 32'h0000_0000;
         serial_tx <= brk ? 1'b0 : line_v;
         tx_event  <= flags[`AST_FL_TXEV];
         rx_event  <= flags[`AST_FL_RXEV];
      end
   end

   // Checks on the block's own behaviour.
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence s_false_start;
      r_fls ##1 rst == ast_pkg::AST_IDLE;
   endsequence

   a_break_line_low: assert property (brk |=> !serial_tx)
      else $error("break did not pull the line low");
   a_idle_line_high: assert property
      (tst == ast_pkg::AST_IDLE && !brk |=> serial_tx)
      else $error("idle transmit line not high");
   a_start_bit_low: assert property
      (tst == ast_pkg::AST_START && !brk |=> !serial_tx)
      else $error("start bit not low");
   a_busy_after_write: assert property (tx_push |=> busy_w[*2])
      else $error("busy not raised by a queued character");
   a_false_start_seen: assert property
      (r_fls |-> s_false_start ##0 rsr[`AST_RS_SE])
      else $error("false start not dropped and reported");
   a_overrun_drop: assert property
      (r_ovr && !rx_pop |=> rx_cnt == $past(rx_cnt) && rsr[`AST_RS_OE])
      else $error("overrun did not discard and flag");
   a_cfg_only_lctl: assert property (!wr_lctl |=> $stable(cfg))
      else $error("settings changed without a line write");
   a_single_entry: assert property (!fifo_enable |-> tx_cnt <= 1 && rx_cnt <= 1)
      else $error("FIFO exceeded one entry while disabled");
   a_rx_needs_enable: assert property
      (rst == ast_pkg::AST_IDLE && !(en && pctl[`AST_PC_RXE])
       |=> rst == ast_pkg::AST_IDLE)
      else $error("receiver started while disabled");
endmodule // ast_serial_core

// ### testbench/ast_far_station.sv
/*
 * Remote serial station: sends frames to the block, captures its
 * frames. Assumes one bit lasts BIT_CLKS system clocks.
 */
`timescale 1ns/1ps

module ast_far_station #(
   parameter int BIT_CLKS = 16          // Clocks in one bit period.
) (
   input  wire logic        clk_sys,    // System clock.
   input  wire logic        serial_tx,  // Line driven by the block.
   input  wire logic        listen,     // Frames are captured when high.
   input  wire logic [3:0]  frame_len,  // Bits that follow the start bit.
   output logic             serial_rx,  // Line driven towards the block.
   output logic      [11:0] cap_bits,   // Captured bits, first in bit 0.
   output logic             cap_valid   // One-cycle pulse per frame.
);
   // The line idles high and nothing has been captured yet.
   initial begin
      serial_rx = 1'b1;
      cap_bits = '0;
      cap_valid = 1'b0;
   end

   // Checks the start bit at its middle, then samples every later bit
   // at its middle, clear of the edges.
   always begin : capture
      @(negedge serial_tx);
      repeat (BIT_CLKS / 2) @(posedge clk_sys);
      if (serial_tx == 1'b0 && listen) begin
         cap_bits <= '0;
         for (int i = 0; i < frame_len; i++) begin
            repeat (BIT_CLKS) @(posedge clk_sys);
            cap_bits[i] <= serial_tx;
         end
         cap_valid <= 1'b1;
         @(posedge clk_sys);
         cap_valid <= 1'b0;
      end
   end

   // Sends a start bit, then len bits lowest first; idles high.
   task automatic send(input logic [11:0] bits, input int len);
      serial_rx <= 1'b0;
      repeat (BIT_CLKS) @(posedge clk_sys);
      for (int i = 0; i < len; i++) begin
         serial_rx <= bits[i];
         repeat (BIT_CLKS) @(posedge clk_sys);
      end
      serial_rx <= 1'b1;
   endtask

   // Pulls the line low for n clocks: a false start.
   task automatic glitch(input int n);
      serial_rx <= 1'b0;
      repeat (n) @(posedge clk_sys);
      serial_rx <= 1'b1;
      repeat (BIT_CLKS) @(posedge clk_sys);
   endtask
endmodule // ast_far_station

// ### testbench/tb_top.sv
/*
 * Self-checking bench: registers by plain port, frames by far station.
 * Assumes divisor 1.0: one oversample tick per clock.
 */
`timescale 1ns/1ps
`include "ast_defines.svh"

module tb_top;
   localparam int LIMIT = 60000;        // Cycle ceiling of the whole run.
   // Line settings: 8N1, 5O1, 6E1, 7O2, stick 0, stick 1, 8E2, 6N2.
   localparam logic [7:0] LC_TAB [8] = '{8'h70, 8'h12, 8'h36, 8'h5A,
                                         8'hF6, 8'h92, 8'h7E, 8'h38};
   localparam int RX_THR [5] = '{2, 4, 8, 12, 14}; // Receive trigger fills.
   logic        clk_sys = 1'b0;         // System clock.
   logic        rst_n;                  // Reset, active low.
   logic [11:0] addr;                   // Register address.
   logic [31:0] wr_data;                // Register write data.
   logic        wr;                     // Write strobe.
   logic        rd;                     // Read strobe.
   logic [31:0] rd_data;                // Read data.
   logic        serial_rx;              // Line into the block.
   logic        serial_tx;              // Line out of the block.
   logic        tx_event;               // Transmit level flag.
   logic        rx_event;               // Receive level flag.
   logic        listen;                 // Far station captures frames.
   logic [3:0]  frame_len;              // Bits expected after a start.
   logic [11:0] cap_bits;               // Frame seen by the station.
   logic        cap_valid;              // Station finished a frame.
   logic        rd_seen = 1'b0;         // A read was taken last edge.
   logic [63:0] note;                   // Oldest read note.
   logic [63:0] rdq[$];                 // Read notes: expected, mask.
   logic [11:0] txq[$];                 // Frames the station should see.
   int          miscompares = 0;        // Mismatches counted.
   int          tests_run = 0;          // Comparisons made.
   int          cyc = 0;                // Clock cycles run.

   ast_serial_core u_ast_serial_core (
      .clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
      .wr(wr), .rd(rd), .rd_data(rd_data), .serial_rx(serial_rx),
      .serial_tx(serial_tx), .tx_event(tx_event), .rx_event(rx_event));
   ast_far_station u_ast_far_station (
      .clk_sys(clk_sys), .serial_tx(serial_tx), .listen(listen),
      .frame_len(frame_len), .serial_rx(serial_rx),
      .cap_bits(cap_bits), .cap_valid(cap_valid));

   // Clock of 20 ns period.
   always #10 clk_sys = ~clk_sys;

   // Compares one value and counts the result.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Prints counts and verdict, then ends the run.
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // One bus cycle; a read notes expected value and mask.
   task automatic bus(input logic w, input logic [11:0] a,
                      input logic [31:0] d,
                      input logic [31:0] m = 32'hFFFF_FFFF);
      @(posedge clk_sys);
      addr <= a;
      wr <= w;
      rd <= !w;
      wr_data <= d;
      if (!w) rdq.push_back({d & m, m});
      @(posedge clk_sys);
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   // Disables port, latches divisor 1.0 and lc, enables.
   task automatic setup(input logic [7:0] lc);
      bus(1'b1, `AST_OFS_PCTL, 32'h0000_0300);
      bus(1'b1, `AST_OFS_IDIV, 32'h0000_0001);
      bus(1'b1, `AST_OFS_FDIV, 32'h0000_0000);
      bus(1'b1, `AST_OFS_LCTL, {24'h00_0000, lc});
      bus(1'b1, `AST_OFS_IDIV, 32'h0000_0007);
      bus(1'b1, `AST_OFS_PCTL, 32'h0000_0301);
   endtask

   // Bits after the start bit for data d under setting lc.
   function automatic logic [11:0] frame(input logic [7:0] d,
                                         input logic [7:0] lc,
                                         output int len);
      logic [11:0] v;
      logic        p;
      len = 5 + lc[`AST_LC_WLEN +: 2];
      v = {4'h0, d} & ((12'h001 << len) - 12'h001);
      p = ^v;
      if (lc[`AST_LC_SPS]) p = ~lc[`AST_LC_EPS];
      else if (!lc[`AST_LC_EPS]) p = ~p;
      if (lc[`AST_LC_PEN]) v[len++] = p;
      v[len++] = 1'b1;
      if (lc[`AST_LC_STP2]) v[len++] = 1'b1;
      return v;
   endfunction

   // Waits, bounded, for every expected frame.
   task automatic drain();
      for (int k = 0; k < 6000 && txq.size() != 0; k++) @(posedge clk_sys);
      repeat (12) @(posedge clk_sys);
   endtask

   // Compares reads and captured frames with the oldest notes.
   always @(posedge clk_sys) begin
      if (rd_seen) begin
         note = rdq.pop_front();
         check(rd_data & note[31:0], note[63:32]);
      end
      rd_seen <= rd;
      if (cap_valid) check(32'(cap_bits), 32'(txq.pop_front()));
   end

   // Cuts a hung run short.
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc >= LIMIT) begin
         miscompares++;
         report_and_stop();
      end
   end

   // Main sequence of tests.
   initial begin : main
      logic [11:0] v;
      logic [7:0]  d;
      logic [7:0]  e;
      int          n;
      rst_n = 1'b0;
      addr = '0;
      wr_data = '0;
      wr = 1'b0;
      rd = 1'b0;
      listen = 1'b1;
      frame_len = '0;
      void'($urandom(98));
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      bus(1'b0, `AST_OFS_PCTL, 32'h0000_0300);
      bus(1'b0, `AST_OFS_LVL, 32'h0000_0012);
      bus(1'b0, `AST_OFS_FLAG, 32'h0000_0090, 32'h0000_00F8);
      bus(1'b0, 12'h040, 32'h0000_0000);
      check(32'(tx_event), 32'h0000_0001);
      check(32'(serial_tx), 32'h0000_0001);
      $display("test reset values done");
      for (int c = 0; c < 8; c++) begin
         setup(LC_TAB[c]);
         d = 8'($urandom);
         v = frame(d, LC_TAB[c], n);
         frame_len <= n[3:0];
         txq.push_back(v);
         bus(1'b1, `AST_OFS_DATA, {24'h00_0000, d});
         bus(1'b0, `AST_OFS_FLAG, 32'h0000_0008, 32'h0000_0008);
         drain();
         bus(1'b0, `AST_OFS_FLAG, 32'h0000_0000, 32'h0000_0008);
         u_ast_far_station.send(v, n);
         bus(1'b0, `AST_OFS_DATA, {24'h00_0000, v[7:0]},
             32'h0000_0F00 | 32'h0000_00FF >> (3 - LC_TAB[c][6:5]));
      end
      $display("test formats done");
      setup(8'h76);
      d = 8'($urandom);
      v = frame(d, 8'h76, n);
      u_ast_far_station.send(v ^ 12'h100, n);
      bus(1'b0, `AST_OFS_DATA, {20'h0_0000, 4'h2, d});
      u_ast_far_station.send(v & 12'hDFF, n);
      bus(1'b0, `AST_OFS_DATA, {20'h0_0000, 4'h1, d});
      u_ast_far_station.send(12'h000, n);
      bus(1'b0, `AST_OFS_DATA, 32'h0000_0400, 32'h0000_04FF);
      u_ast_far_station.glitch(4);
      bus(1'b0, `AST_OFS_RSTAT, 32'h0000_0010, 32'h0000_0010);
      bus(1'b1, `AST_OFS_RSTAT, 32'h0000_0000);
      bus(1'b0, `AST_OFS_RSTAT, 32'h0000_0000);
      $display("test receive done");
      setup(8'h60);
      d = 8'($urandom);
      e = ~d;
      u_ast_far_station.send({3'h1, d}, 9);
      u_ast_far_station.send({3'h1, e}, 9);
      bus(1'b0, `AST_OFS_FLAG, 32'h0000_0040, 32'h0000_0040);
      bus(1'b0, `AST_OFS_RSTAT, 32'h0000_0008, 32'h0000_0008);
      bus(1'b0, `AST_OFS_DATA, {24'h00_0000, d}, 32'h0000_00FF);
      setup(8'h70);
      u_ast_far_station.send({3'h1, d}, 9);
      u_ast_far_station.send({3'h1, e}, 9);
      for (int k = 0; k < 5; k++) begin
         bus(1'b1, `AST_OFS_LVL, {26'h0, k[2:0], 3'h2});
         repeat (2) @(posedge clk_sys);
         check(32'(rx_event), 32'(RX_THR[k] <= 2));
      end
      bus(1'b0, `AST_OFS_DATA, {24'h00_0000, d}, 32'h0000_00FF);
      bus(1'b0, `AST_OFS_DATA, {24'h00_0000, e}, 32'h0000_00FF);
      $display("test overrun and levels done");
      bus(1'b1, `AST_OFS_PCTL, 32'h0000_0300);
      frame_len <= 4'h9;
      for (int k = 0; k < 17; k++) begin
         d = 8'($urandom);
         if (k < 16) txq.push_back({3'h1, d});
         bus(1'b1, `AST_OFS_DATA, {24'h00_0000, d});
      end
      bus(1'b0, `AST_OFS_FLAG, 32'h0000_0028, 32'h0000_0028);
      check(32'(tx_event), 32'h0000_0000);
      bus(1'b1, `AST_OFS_PCTL, 32'h0000_0301);
      repeat (40) @(posedge clk_sys);
      bus(1'b1, `AST_OFS_PCTL, 32'h0000_0300);
      repeat (400) @(posedge clk_sys);
      check(32'(txq.size()), 32'd15);
      bus(1'b0, `AST_OFS_FLAG, 32'h0000_0008, 32'h0000_0008);
      bus(1'b1, `AST_OFS_PCTL, 32'h0000_0301);
      drain();
      check(32'(txq.size()), 32'd0);
      $display("test transmit queue done");
      listen <= 1'b0;
      bus(1'b1, `AST_OFS_LCTL, 32'h0000_0071);
      repeat (3) @(posedge clk_sys);
      check(32'(serial_tx), 32'h0000_0000);
      repeat (300) @(posedge clk_sys);
      bus(1'b1, `AST_OFS_LCTL, 32'h0000_0070);
      repeat (3) @(posedge clk_sys);
      check(32'(serial_tx), 32'h0000_0001);
      $display("test line break done");
      report_and_stop();
   end
endmodule // tb_top
